// ---- hdl/host_bridge_ordering_flush.sv ----
// Ordering, flush-before-read, speculative request and strap logic of the host bridge
`include "bridge_defines.svh"

module host_bridge_ordering_flush
  import bridge_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Processor-side slave
  input wire logic transfer_start_strobe,
  input wire kind_t cpu_kind,
  input wire logic [31:0] cpu_data,
  output logic cpu_wait,
  output logic cpu_done,
  output logic cpu_retry,
  // PCI-side slave
  input wire logic pci_frame_start,
  input wire kind_t pci_kind,
  input wire logic [31:0] pci_data,
  output logic pci_wait,
  output logic pci_done,
  output logic pci_retry,
  // Toward the PCI master
  output logic pci_out_valid,
  input wire logic pci_out_ready,
  output kind_t pci_out_kind,
  output logic [31:0] pci_out_data,
  // Toward the processor master
  output logic cpu_out_valid,
  input wire logic cpu_out_ready,
  output kind_t cpu_out_kind,
  output logic [31:0] cpu_out_data,
  // Posted-write pending flags
  output logic cpu_posted_pending_abort,
  output logic pci_posted_pending_abort,
  // Speculative request
  input wire logic lock_resolve,
  input wire logic pci_clk,
  output logic pci_req_n,
  // Straps
  input wire logic req64_n,
  input wire logic [12:5] strap_rd,
  output logic strap_valid,
  output logic pci64_en,
  output logic [31:0] reg_base,
  output logic serial_int_sel,
  output logic cpu_arb_en,
  output logic pci_arb_en,
  output ratio_t clk_ratio,
  output logic ratio_reserved,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic is_ordered(input kind_t k);
    is_ordered = (k == KIND_READ) || (k == KIND_COMPELLED);
  endfunction : is_ordered

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `REG_CTRL_OFS) || (a == `REG_STATUS_OFS) || (a == `REG_STRAP_OFS);
  endfunction : mapped

  stream_if #(.W(PAY_W)) to_pci_in ();
  stream_if #(.W(PAY_W)) to_pci_out ();
  stream_if #(.W(PAY_W)) to_cpu_in ();
  stream_if #(.W(PAY_W)) to_cpu_out ();

  logic to_pci_empty, to_cpu_empty;
  logic [2:0] ctrl_r;
  logic cpu_flush, pci_flush, spec_en;
  xfer_st_t cpu_st_r, pci_st_r;
  kind_t cpu_kind_r, pci_kind_r;
  logic [31:0] cpu_data_r, pci_data_r;
  logic [3:0] cpu_dec_r, pci_dec_r;
  logic cpu_wait_r, cpu_done_r, cpu_retry_r;
  logic pci_wait_r, pci_done_r, pci_retry_r;
  logic cpu_pend_r, pci_pend_r;
  logic pclk_s1_r, pclk_s2_r, pclk_s3_r, pclk_lvl_r, pci_rise;
  logic spec_req_n_r;
  logic [4:0] spec_cnt_r;
  logic rst_q_r;
  logic [8:0] strap_cap_r, strap_d1_r, strap_d2_r;
  logic [2:0] strap_sr_r;
  strap_t strap_r;
  logic [31:0] reg_base_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic quiet, aw_ok, ar_ok;
  status_t status;

  assign cpu_flush = ctrl_r[`CTRL_CPU_FLUSH_BIT];
  assign pci_flush = ctrl_r[`CTRL_PCI_FLUSH_BIT];
  assign spec_en = ctrl_r[`CTRL_SPEC_BIT];

  // Both directions share one in-order path each
  stream_buf #(.W(PAY_W), .DEPTH(BUF_DEPTH)) u_to_pci (
    .clk(mclk),
    .rst(rst),
    .push(to_pci_in),
    .pop(to_pci_out),
    .empty(to_pci_empty)
  );

  stream_buf #(.W(PAY_W), .DEPTH(BUF_DEPTH)) u_to_cpu (
    .clk(mclk),
    .rst(rst),
    .push(to_cpu_in),
    .pop(to_cpu_out),
    .empty(to_cpu_empty)
  );

  assign to_pci_in.valid = (cpu_st_r == ST_PUSH);
  assign to_pci_in.data = {cpu_kind_r, cpu_data_r};
  assign to_pci_out.ready = pci_out_ready;
  assign pci_out_valid = to_pci_out.valid;
  assign pci_out_kind = kind_t'(to_pci_out.data[33:32]);
  assign pci_out_data = to_pci_out.data[31:0];

  assign to_cpu_in.valid = (pci_st_r == ST_PUSH);
  assign to_cpu_in.data = {pci_kind_r, pci_data_r};
  assign to_cpu_out.ready = cpu_out_ready;
  assign cpu_out_valid = to_cpu_out.valid;
  assign cpu_out_kind = kind_t'(to_cpu_out.data[33:32]);
  assign cpu_out_data = to_cpu_out.data[31:0];

  // Processor-side slave sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      cpu_st_r <= ST_IDLE;
      cpu_kind_r <= KIND_READ;
      cpu_data_r <= 32'h0;
      cpu_dec_r <= 4'h0;
      cpu_wait_r <= 1'b0;
      cpu_done_r <= 1'b0;
      cpu_retry_r <= 1'b0;
    end else begin
      cpu_done_r <= 1'b0;
      cpu_retry_r <= 1'b0;
      unique case (cpu_st_r)
        ST_IDLE: begin
          if (transfer_start_strobe) begin
            cpu_kind_r <= cpu_kind;
            cpu_data_r <= cpu_data;
            cpu_dec_r <= 4'h0;
            cpu_wait_r <= 1'b1;
            cpu_st_r <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          if (cpu_dec_r == `DECODE_SETTLE_CLKS - 4'h1) begin
            if (cpu_kind_r == KIND_READ && cpu_flush && pci_pend_r) begin
              cpu_retry_r <= 1'b1;
              cpu_wait_r <= 1'b0;
              cpu_st_r <= ST_IDLE;
            end else if (is_ordered(cpu_kind_r)) begin
              cpu_st_r <= ST_DRAIN;
            end else begin
              cpu_st_r <= ST_PUSH;
            end
          end else begin
            cpu_dec_r <= cpu_dec_r + 4'h1;
          end
        end
        ST_DRAIN: begin
          // Wait states until earlier posted writes have left
          if (to_pci_empty) begin
            cpu_st_r <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (to_pci_in.ready) begin
            if (is_ordered(cpu_kind_r)) begin
              cpu_st_r <= ST_FINISH;
            end else begin
              cpu_done_r <= 1'b1;
              cpu_wait_r <= 1'b0;
              cpu_st_r <= ST_IDLE;
            end
          end
        end
        ST_FINISH: begin
          if (to_pci_empty) begin
            cpu_done_r <= 1'b1;
            cpu_wait_r <= 1'b0;
            cpu_st_r <= ST_IDLE;
          end
        end
        default: begin
          cpu_wait_r <= 1'b0;
          cpu_st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // PCI-side slave sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      pci_st_r <= ST_IDLE;
      pci_kind_r <= KIND_READ;
      pci_data_r <= 32'h0;
      pci_dec_r <= 4'h0;
      pci_wait_r <= 1'b0;
      pci_done_r <= 1'b0;
      pci_retry_r <= 1'b0;
    end else begin
      pci_done_r <= 1'b0;
      pci_retry_r <= 1'b0;
      unique case (pci_st_r)
        ST_IDLE: begin
          if (pci_frame_start) begin
            pci_kind_r <= pci_kind;
            pci_data_r <= pci_data;
            pci_dec_r <= 4'h0;
            pci_wait_r <= 1'b1;
            pci_st_r <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          if (pci_dec_r == `DECODE_SETTLE_CLKS - 4'h1) begin
            if (pci_kind_r == KIND_READ && pci_flush && cpu_pend_r) begin
              pci_retry_r <= 1'b1;
              pci_wait_r <= 1'b0;
              pci_st_r <= ST_IDLE;
            end else if (is_ordered(pci_kind_r)) begin
              pci_st_r <= ST_DRAIN;
            end else begin
              pci_st_r <= ST_PUSH;
            end
          end else begin
            pci_dec_r <= pci_dec_r + 4'h1;
          end
        end
        ST_DRAIN: begin
          // PCI wait states until the processor-bound path is empty
          if (to_cpu_empty) begin
            pci_st_r <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (to_cpu_in.ready) begin
            if (is_ordered(pci_kind_r)) begin
              pci_st_r <= ST_FINISH;
            end else begin
              pci_done_r <= 1'b1;
              pci_wait_r <= 1'b0;
              pci_st_r <= ST_IDLE;
            end
          end
        end
        ST_FINISH: begin
          if (to_cpu_empty) begin
            pci_done_r <= 1'b1;
            pci_wait_r <= 1'b0;
            pci_st_r <= ST_IDLE;
          end
        end
        default: begin
          pci_wait_r <= 1'b0;
          pci_st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Pending flags: set on commit, wins over the drain-to-empty clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      cpu_pend_r <= 1'b0;
      pci_pend_r <= 1'b0;
    end else begin
      if (cpu_st_r == ST_DECODE && cpu_dec_r == `DECODE_SETTLE_CLKS - 4'h1
          && cpu_kind_r == KIND_POSTED) begin
        cpu_pend_r <= 1'b1;
      end else if (to_pci_empty && cpu_st_r != ST_PUSH) begin
        cpu_pend_r <= 1'b0;
      end
      if (pci_st_r == ST_DECODE && pci_dec_r == `DECODE_SETTLE_CLKS - 4'h1
          && pci_kind_r == KIND_POSTED) begin
        pci_pend_r <= 1'b1;
      end else if (to_cpu_empty && pci_st_r != ST_PUSH) begin
        pci_pend_r <= 1'b0;
      end
    end
  end

  // PCI clock seen through three flops; edge counts once stages two and three agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      pclk_s1_r <= 1'b0;
      pclk_s2_r <= 1'b0;
      pclk_s3_r <= 1'b0;
      pclk_lvl_r <= 1'b0;
    end else begin
      pclk_s1_r <= pci_clk;
      pclk_s2_r <= pclk_s1_r;
      pclk_s3_r <= pclk_s2_r;
      if (pclk_s2_r == pclk_s3_r) begin
        pclk_lvl_r <= pclk_s3_r;
      end
    end
  end

  assign pci_rise = (pclk_s2_r == pclk_s3_r) && pclk_s3_r && !pclk_lvl_r;

  // Speculative request; a benign request never outlives its window
  always_ff @(posedge mclk) begin
    if (rst) begin
      spec_req_n_r <= 1'b1;
      spec_cnt_r <= 5'h0;
    end else if (!spec_en) begin
      spec_req_n_r <= 1'b1;
      spec_cnt_r <= 5'h0;
    end else if (spec_req_n_r && lock_resolve && cpu_st_r != ST_IDLE
                 && is_ordered(cpu_kind_r)) begin
      spec_req_n_r <= 1'b0;
      spec_cnt_r <= 5'h0;
    end else if (!spec_req_n_r && pci_rise) begin
      if (spec_cnt_r == `SPEC_LIMIT_CLKS - 5'h1) begin
        spec_req_n_r <= 1'b1;
      end
      spec_cnt_r <= spec_cnt_r + 5'h1;
    end
  end

  // Straps: caught at the first edge after release, then two more stages for hold margin
  always_ff @(posedge mclk) begin
    rst_q_r <= rst;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_cap_r <= 9'h0;
      strap_d1_r <= 9'h0;
      strap_d2_r <= 9'h0;
      strap_sr_r <= 3'h0;
    end else begin
      if (rst_q_r) begin
        strap_cap_r <= {req64_n, strap_rd};
      end
      strap_d1_r <= strap_cap_r;
      strap_d2_r <= strap_d1_r;
      strap_sr_r <= {strap_sr_r[1:0], rst_q_r | strap_sr_r[0]};
    end
  end

  // Offsets into strap_cap_r: bit 8 is req64, bits 7..0 are strap_rd[12:5]
  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_r <= '0;
      reg_base_r <= `REG_BASE_SEL0;
    end else if (strap_sr_r[2] && !strap_r.valid) begin
      strap_r.valid <= 1'b1;
      strap_r.pci64_en <= !strap_d2_r[8];
      strap_r.base_sel <= strap_d2_r[`STRAP_BASE_BIT - 5];
      reg_base_r <= strap_d2_r[`STRAP_BASE_BIT - 5] ? `REG_BASE_SEL1 : `REG_BASE_SEL0;
      strap_r.serial_int <= strap_d2_r[`STRAP_INT_BIT - 5];
      strap_r.cpu_arb_en <= strap_d2_r[`STRAP_CPU_ARB_BIT - 5];
      strap_r.pci_arb_en <= strap_d2_r[`STRAP_PCI_ARB_BIT - 5];
      strap_r.ratio <= ratio_t'({strap_d2_r[`STRAP_RATIO_A_BIT - 5],
                                 strap_d2_r[`STRAP_RATIO_B_BIT - 5],
                                 strap_d2_r[`STRAP_RATIO_C_BIT - 5]});
      // Reserved codes are only flagged; the board must avoid them
      strap_r.ratio_reserved <= !strap_d2_r[`STRAP_RATIO_A_BIT - 5]
                                && !strap_d2_r[`STRAP_RATIO_B_BIT - 5]
                                && !strap_d2_r[`STRAP_RATIO_C_BIT - 5]
                                || strap_d2_r[`STRAP_RATIO_A_BIT - 5]
                                && strap_d2_r[`STRAP_RATIO_C_BIT - 5];
    end
  end

  // Register access held off until every posted write has landed
  assign quiet = to_pci_empty && to_cpu_empty && !cpu_pend_r && !pci_pend_r;
  assign aw_ok = s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r && quiet;
  assign ar_ok = s_axi_arvalid && !arready_r && !rvalid_r && quiet;

  always_ff @(posedge mclk) begin
    if (rst) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `AXI_RESP_OKAY;
    end else begin
      awready_r <= aw_ok;
      wready_r <= aw_ok;
      if (awready_r) begin
        bvalid_r <= 1'b1;
        bresp_r <= (s_axi_awaddr == `REG_CTRL_OFS) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Control bits change only by a software write
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r <= `CTRL_RESET;
    end else if (awready_r && s_axi_awaddr == `REG_CTRL_OFS && s_axi_wstrb[0]) begin
      ctrl_r <= s_axi_wdata[2:0];
    end
  end

  always_comb begin
    status = '0;
    status.pci_busy = (pci_st_r != ST_IDLE);
    status.cpu_busy = (cpu_st_r != ST_IDLE);
    status.spec_req_active = !spec_req_n_r;
    status.to_cpu_empty = to_cpu_empty;
    status.to_pci_empty = to_pci_empty;
    status.pci_pend = pci_pend_r;
    status.cpu_pend = cpu_pend_r;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `AXI_RESP_OKAY;
    end else begin
      arready_r <= ar_ok;
      if (arready_r) begin
        rvalid_r <= 1'b1;
        rresp_r <= mapped(s_axi_araddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        if (s_axi_araddr == `REG_CTRL_OFS) begin
          rdata_r <= {29'h0, ctrl_r};
        end else if (s_axi_araddr == `REG_STATUS_OFS) begin
          rdata_r <= {25'h0, status};
        end else if (s_axi_araddr == `REG_STRAP_OFS) begin
          rdata_r <= {22'h0, strap_r};
        end else begin
          rdata_r <= 32'h0;
        end
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign cpu_wait = cpu_wait_r;
  assign cpu_done = cpu_done_r;
  assign cpu_retry = cpu_retry_r;
  assign pci_wait = pci_wait_r;
  assign pci_done = pci_done_r;
  assign pci_retry = pci_retry_r;
  assign cpu_posted_pending_abort = cpu_pend_r;
  assign pci_posted_pending_abort = pci_pend_r;
  assign pci_req_n = spec_req_n_r;
  assign strap_valid = strap_r.valid;
  assign pci64_en = strap_r.pci64_en;
  assign reg_base = reg_base_r;
  assign serial_int_sel = strap_r.serial_int;
  assign cpu_arb_en = strap_r.cpu_arb_en;
  assign pci_arb_en = strap_r.pci_arb_en;
  assign clk_ratio = strap_r.ratio;
  assign ratio_reserved = strap_r.ratio_reserved;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule : host_bridge_ordering_flush

// ---- hdl/bridge_defines.svh ----
// Register offsets, reset values, strap positions and timing counts of the bridge
`ifndef BRIDGE_DEFINES_SVH
`define BRIDGE_DEFINES_SVH

// Register byte offsets
`define REG_CTRL_OFS 12'h000
`define REG_STATUS_OFS 12'h004
`define REG_STRAP_OFS 12'h008

// Control register fields
`define CTRL_SPEC_BIT 0
`define CTRL_CPU_FLUSH_BIT 1
`define CTRL_PCI_FLUSH_BIT 2
`define CTRL_RESET 3'h1

// Strap pin positions
`define STRAP_BASE_BIT 5
`define STRAP_INT_BIT 7
`define STRAP_CPU_ARB_BIT 8
`define STRAP_PCI_ARB_BIT 9
`define STRAP_RATIO_A_BIT 10
`define STRAP_RATIO_B_BIT 11
`define STRAP_RATIO_C_BIT 12

// Register block base addresses
`define REG_BASE_SEL0 32'hfeff0000
`define REG_BASE_SEL1 32'hfefe0000

// Timing counts
`define SPEC_LIMIT_CLKS 5'h10
`define DECODE_SETTLE_CLKS 4'h3

// AXI responses
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ---- hdl/bridge_pkg.sv ----
// Types shared by the bridge ordering logic
package bridge_pkg;

  typedef enum logic [1:0] {
    KIND_READ = 2'h0,
    KIND_POSTED = 2'h1,
    KIND_COMPELLED = 2'h2
  } kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DECODE = 3'h1,
    ST_DRAIN = 3'h3,
    ST_PUSH = 3'h2,
    ST_FINISH = 3'h6
  } xfer_st_t;

  typedef enum logic [2:0] {
    RATIO_RSV0 = 3'h0,
    RATIO_1_1 = 3'h4,
    RATIO_2_1 = 3'h2,
    RATIO_3_1 = 3'h6,
    RATIO_3_2 = 3'h1,
    RATIO_RSV5 = 3'h5,
    RATIO_5_2 = 3'h3,
    RATIO_RSV7 = 3'h7
  } ratio_t;

  typedef struct packed {
    logic ratio_reserved;
    ratio_t ratio;
    logic pci_arb_en;
    logic cpu_arb_en;
    logic serial_int;
    logic base_sel;
    logic pci64_en;
    logic valid;
  } strap_t;

  typedef struct packed {
    logic pci_busy;
    logic cpu_busy;
    logic spec_req_active;
    logic to_cpu_empty;
    logic to_pci_empty;
    logic pci_pend;
    logic cpu_pend;
  } status_t;

  localparam int PAY_W = 34;

endpackage : bridge_pkg

// ---- hdl/stream_if.sv ----
// Valid/ready stream between the bridge and its posted-write buffers
interface stream_if #(parameter int W = 34);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// ---- hdl/stream_buf.sv ----
// Small in-order buffer with valid/ready on both sides
module stream_buf #(
  parameter int W = 34,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Streams
  stream_if.snk push,
  stream_if.src pop,
  // Status
  output logic empty
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic full_r, val_r;
  logic do_push, do_pop;

  assign do_push = push.valid && !full_r;
  assign do_pop = val_r && pop.ready;
  assign push.ready = !full_r;
  assign pop.valid = val_r;
  assign pop.data = mem_r[rp_r];
  assign empty = !val_r;

  always_comb begin
    cnt_nxt = cnt_r;
    if (do_push && !do_pop) begin
      cnt_nxt = cnt_r + CW'(1);
    end else if (do_pop && !do_push) begin
      cnt_nxt = cnt_r - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      full_r <= 1'b0;
      val_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      full_r <= (cnt_nxt == FULL_CNT);
      val_r <= (cnt_nxt != '0);
    end
  end

  // Flops in order, so words leave as they came in
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (do_push) begin
        wp_r <= (wp_r == LAST_PTR) ? '0 : wp_r + AW'(1);
      end
      if (do_pop) begin
        rp_r <= (rp_r == LAST_PTR) ? '0 : rp_r + AW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_r[wp_r] <= push.data;
    end
  end

endmodule : stream_buf

// ---- verif/bridge_assertions.sv ----
// Checker of strap decode, speculative request, register gating and stream hold
module bridge_assertions
  import bridge_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Straps
  input wire logic req64_n,
  input wire logic [12:5] strap_rd,
  input wire logic strap_valid,
  input wire logic pci64_en,
  input wire logic [31:0] reg_base,
  input wire logic serial_int_sel,
  input wire logic cpu_arb_en,
  input wire logic pci_arb_en,
  input wire ratio_t clk_ratio,
  // Traffic
  input wire logic lock_resolve,
  input wire logic pci_req_n,
  input wire logic pci_out_valid,
  input wire logic pci_out_ready,
  input wire logic [31:0] pci_out_data,
  input wire logic cpu_posted_pending_abort,
  input wire logic pci_posted_pending_abort,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [7:0] low_r;
  // Bound allows for first edge phase and sync lag
  always_ff @(posedge mclk) begin
    if (rst || pci_req_n) begin
      low_r <= 8'h00;
    end else if (low_r != 8'hff) begin
      low_r <= low_r + 8'h01;
    end
  end
  strap_width_a: assert property (strap_valid |-> pci64_en == !req64_n)
    else $error("strap width");
  strap_base_a: assert property (strap_valid |->
    reg_base == (strap_rd[5] ? 32'hfefe0000 : 32'hfeff0000)) else $error("strap base");
  strap_mode_a: assert property (strap_valid |-> serial_int_sel == strap_rd[7] &&
    cpu_arb_en == strap_rd[8] && pci_arb_en == strap_rd[9]) else $error("strap modes");
  strap_ratio_a: assert property (strap_valid |->
    clk_ratio == {strap_rd[10], strap_rd[11], strap_rd[12]}) else $error("strap ratio");
  strap_late_a: assert property ($fell(rst) |-> ##[1:6] strap_valid)
    else $error("strap late");
  spec_drop_a: assert property (low_r <= 8'h8c) else $error("spec request held");
  spec_cause_a: assert property ($fell(pci_req_n) |-> $past(lock_resolve))
    else $error("spec request cause");
  reg_gate_a: assert property (s_axi_arready |->
    !$past(cpu_posted_pending_abort) && !$past(pci_posted_pending_abort))
    else $error("reg access early");
  out_hold_a: assert property (pci_out_valid && !pci_out_ready |=>
    pci_out_valid && $stable(pci_out_data)) else $error("stream hold");
  cover property (!pci_req_n);
  cover property (s_axi_bvalid);
  cover property ($fell(pci_out_valid));
endmodule : bridge_assertions

bind host_bridge_ordering_flush bridge_assertions chk_u (.*);

// ---- verif/far_masters.sv ----
// Far-side masters: free-running link clock and stalling stream sinks
module far_masters (
  // Clock and stall control
  input wire logic mclk,
  input wire logic stall,
  // Sinks and link clock
  output logic pci_out_ready,
  output logic cpu_out_ready,
  output logic pci_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pci_clk = 1'b0;
    pci_out_ready = 1'b0;
    cpu_out_ready = 1'b0;
    #3;
    forever #40 pci_clk = ~pci_clk;
  end
  // Processor side stalls in link clock bursts
  always @(posedge mclk) begin
    pci_out_ready <= !stall;
    cpu_out_ready <= pci_clk;
  end
endmodule : far_masters

// ---- verif/host_bridge_ordering_flush_test.sv ----
// Self-checking bench of the host bridge ordering logic
module host_bridge_ordering_flush_test;
  timeunit 1ns;
  timeprecision 1ns;
  import bridge_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, transfer_start_strobe = 1'b0, pci_frame_start = 1'b0;
  logic lock_resolve = 1'b0, req64_n, stall = 1'b0;
  logic [12:5] strap_rd;
  kind_t cpu_kind = KIND_READ, pci_kind = KIND_READ, pci_out_kind, cpu_out_kind;
  logic [31:0] cpu_data = 32'h0, pci_data = 32'h0, pci_out_data, cpu_out_data, reg_base;
  logic cpu_wait, cpu_done, cpu_retry, pci_wait, pci_done, pci_retry, pci_out_valid;
  logic pci_out_ready, cpu_out_valid, cpu_out_ready, cpu_posted_pending_abort, pci_clk;
  logic pci_posted_pending_abort, pci_req_n, strap_valid, pci64_en, serial_int_sel;
  logic cpu_arb_en, pci_arb_en, ratio_reserved, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp, mode = 2'h0;
  logic [2:0] c;
  logic [2:0] rc [5] = '{3'h4, 3'h2, 3'h6, 3'h1, 3'h3};
  ratio_t clk_ratio;
  logic [33:0] pq [$], cq [$];
  int error_cnt = 0, compares = 0, seed = 26540, n, i;
  host_bridge_ordering_flush dut_u (.*);
  far_masters far_u (.*);
  always #5 mclk = ~mclk;
  always @(posedge mclk) stall <= mode[0] || (mode[1] && $random(seed) % 2 != 0);
  always @(posedge mclk) begin
    if (pci_out_valid && pci_out_ready) begin
      chk("to_pci", pq.pop_front(), {pci_out_kind, pci_out_data});
    end
    if (cpu_out_valid && cpu_out_ready) begin
      chk("to_cpu", cq.pop_front(), {cpu_out_kind, cpu_out_data});
    end
  end
  function automatic logic [33:0] sexp(input logic [12:5] s, input logic q);
    return {25'h0, s[10], s[11], s[12], s[9], s[8], s[7], s[5], !q, 1'b1};
  endfunction : sexp
  task chk(input string w, input logic [33:0] e, input logic [33:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", w, e, g);
    end
  endtask : chk
  task conclude;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task tmo(input int k);
    if (k >= 400) begin
      error_cnt++;
      $display("MISMATCH wait exp answer got timeout");
      conclude();
    end
  endtask : tmo
  task axi(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!(s_axi_awready || s_axi_arready) && n < 400);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_arvalid <= 1'b0;
    while (!(s_axi_bvalid || s_axi_rvalid) && n < 400) begin
      @(posedge mclk);
      n++;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    tmo(n);
    chk("axi", e, w ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata});
  endtask : axi
  task xs(input logic p, input kind_t k, input logic [31:0] d, input logic r);
    @(posedge mclk);
    if (p) begin
      pci_frame_start <= 1'b1;
      pci_kind <= k;
      pci_data <= d;
    end else begin
      transfer_start_strobe <= 1'b1;
      cpu_kind <= k;
      cpu_data <= d;
    end
    if (!r && p) cq.push_back({k, d});
    if (!r && !p) pq.push_back({k, d});
    @(posedge mclk);
    pci_frame_start <= 1'b0;
    transfer_start_strobe <= 1'b0;
  endtask : xs
  task xw(input logic p, input logic r);
    n = 0;
    while (!(p ? pci_done || pci_retry : cpu_done || cpu_retry) && n < 400) begin
      @(posedge mclk);
      n++;
    end
    tmo(n);
    chk("retry", {r, 1'b0}, p ? {pci_retry, pci_wait} : {cpu_retry, cpu_wait});
  endtask : xw
  initial begin
    i = {$random(seed)} % 5;
    c = rc[i];
    n = $random(seed);
    strap_rd = {c[0], c[1], c[2], n[4:0]}; // Legal ratio codes only
    req64_n = n[5];
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("req_n", 1, pci_req_n);
    chk("rsv", 0, ratio_reserved);
    axi(0, 12'h008, 0, sexp(strap_rd, req64_n));
    axi(0, 12'h000, 0, 34'h1);
    axi(0, 12'h00c, 0, {2'h2, 32'h0});
    axi(1, 12'h004, 32'hff, {2'h2, 32'h0});
    $display("test straps done");
    mode <= 2'h1;
    for (i = 0; i < 2; i++) begin
      xs(0, KIND_POSTED, $random(seed), 0);
      xw(0, 0);
    end
    chk("pend", 1, cpu_posted_pending_abort);
    mode <= 2'h2;
    xs(0, KIND_READ, $random(seed), 0);
    xw(0, 0);
    chk("pend", 0, cpu_posted_pending_abort);
    for (i = 0; i < 8; i++) begin
      xs(i[0], kind_t'(2'({$random(seed)} % 3)), $random(seed), 0);
      xw(i[0], 0);
    end
    $display("test ordering done");
    axi(1, 12'h000, 32'h3, 34'h0);
    mode <= 2'h1;
    xs(0, KIND_POSTED, $random(seed), 0);
    xw(0, 0);
    xs(1, KIND_READ, $random(seed), 0);
    xw(1, 0);
    xs(1, KIND_POSTED, $random(seed), 0);
    xs(0, KIND_READ, $random(seed), 1);
    xw(0, 1);
    mode <= 2'h0;
    axi(1, 12'h000, 32'h5, 34'h0);
    mode <= 2'h1;
    xs(0, KIND_POSTED, $random(seed), 0);
    xw(0, 0);
    xs(1, KIND_READ, $random(seed), 1);
    xw(1, 1);
    $display("test flush done");
    xs(0, KIND_READ, $random(seed), 0);
    repeat (8) @(posedge mclk);
    lock_resolve <= 1'b1;
    @(posedge mclk);
    lock_resolve <= 1'b0;
    @(posedge mclk);
    chk("spec_on", 0, pci_req_n);
    n = 0;
    while (!pci_req_n && n < 400) begin
      @(posedge mclk);
      n++;
    end
    tmo(n);
    chk("spec_len", 1, n > 110);
    mode <= 2'h0;
    xw(0, 0);
    $display("test spec done");
    chk("left", 0, pq.size() + cq.size());
    conclude();
  end
endmodule : host_bridge_ordering_flush_test
